// ### design/gop_pkg.sv
// shared constants, lookups and types for the gain/offset/power control
package gop_pkg;
    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [7:0] ADR_GAIN  = 8'h00;
    localparam logic [7:0] ADR_OFS   = 8'h01;
    localparam logic [7:0] ADR_PMODE = 8'h02;
    localparam logic [7:0] ADR_STAT  = 8'h03;
    localparam logic [7:0] ADR_CORRA = 8'h04;
    localparam logic [7:0] ADR_CORRB = 8'h05;
    localparam int OFS_EN_BIT = 0;
    localparam int OFS_TC_LSB = 4;
    localparam logic [3:0] GAIN_RST = 4'h0;
    localparam logic [3:0] GAIN_MAX = 4'hc;
    localparam logic [3:0] TC_RST   = 4'h0;
    localparam logic [3:0] TC_MAX   = 4'hb;
    // ---------------------------------------------------------------
    // power mode codes
    // ---------------------------------------------------------------
    localparam logic [3:0] PM_NORM  = 4'h0;
    localparam logic [3:0] PM_BDISB = 4'h9;
    localparam logic [3:0] PM_BDISA = 4'ha;
    localparam logic [3:0] PM_BDIS2 = 4'hb;
    localparam logic [3:0] PM_GLB   = 4'hc;
    localparam logic [3:0] PM_STBYB = 4'hd;
    localparam logic [3:0] PM_STBYA = 4'he;
    localparam logic [3:0] PM_MUX   = 4'hf;
    // ---------------------------------------------------------------
    // datapath and timing
    // ---------------------------------------------------------------
    localparam int DW      = 11;
    localparam int FRAC    = 29;
    localparam int SH_BASE = 18;
    localparam int GK_FRAC = 10;
    localparam int OFS_LIM = 10;
    localparam int CLK_NS  = 10;
    localparam int GLB_NS  = 20000;
    localparam int STBY_NS = 1000;
    localparam int BUF_NS  = 100;
    localparam int SLOW_NS = 1000;
    localparam int GLB_CYC  = (GLB_NS + CLK_NS - 1) / CLK_NS;
    localparam int STBY_CYC = (STBY_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUF_CYC  = (BUF_NS + CLK_NS - 1) / CLK_NS;
    localparam int SLOW_CYC = (SLOW_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic pd_glb;
        logic stby_a;
        logic stby_b;
        logic bdis_a;
        logic bdis_b;
        logic mux;
    } gop_pwr_s;

    // gain factor in Q10 for half-decibel steps
    function automatic logic [11:0] gain_k(input logic [3:0] g);
        case (g)
            4'h0: gain_k = 12'h400;  4'h1: gain_k = 12'h43d;
            4'h2: gain_k = 12'h47d;  4'h3: gain_k = 12'h4c1;
            4'h4: gain_k = 12'h509;  4'h5: gain_k = 12'h554;
            4'h6: gain_k = 12'h5a5;  4'h7: gain_k = 12'h5fb;
            4'h8: gain_k = 12'h656;  4'h9: gain_k = 12'h6b6;
            4'ha: gain_k = 12'h71c;  4'hb: gain_k = 12'h788;
            default: gain_k = 12'h7fb;
        endcase
    endfunction

    // input full-scale span in millivolts peak-to-peak
    function automatic logic [10:0] fs_mv(input logic [3:0] g);
        case (g)
            4'h0: fs_mv = 11'h7d0;  4'h1: fs_mv = 11'h760;
            4'h2: fs_mv = 11'h6f4;  4'h3: fs_mv = 11'h691;
            4'h4: fs_mv = 11'h636;  4'h5: fs_mv = 11'h5da;
            4'h6: fs_mv = 11'h58c;  4'h7: fs_mv = 11'h537;
            4'h8: fs_mv = 11'h4ec;  4'h9: fs_mv = 11'h4a5;
            4'ha: fs_mv = 11'h460;  4'hb: fs_mv = 11'h424;
            default: fs_mv = 11'h3e8;
        endcase
    endfunction
endpackage

// ### design/gop_ctrl.sv
// gain, dc offset loop and power-down control of a two-channel converter
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
// Operation
// - gain 0 to 6 dB, half-dB steps
// - gain resets to 0 dB
// - full-scale span shrinks with gain
// - offset loop removes up to 10 mV
// - enabled loop updates every clk cycle, not per samp_tick
// - four-bit time constant, top codes reserved
// - disable freezes and keeps applying estimate
// - offset correction off after reset
// - power mode from register or pins
// - codes 0, 9, a, b: buffer control
// - global power down, 20 us wake
// - channel standby, 1 us wake
// - disabled buffer floats, 100 ns wake
// - mux mode interleaves onto channel A
// - slow sample clock enters low power
// - registers are 8-bit address, 8-bit data
module gop_ctrl #(
    parameter int DW = gop_pkg::DW
) (
    input  wire logic          clk,
    input  wire logic          srst,
    input  wire logic [7:0]    reg_addr,
    input  wire logic [7:0]    reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [7:0]    reg_rdata,
    input  wire logic          ctl_pin_one,
    input  wire logic          ctl_pin_two,
    input  wire logic          ctl_pin_three,
    input  wire logic          samp_tick,
    input  wire logic [DW-1:0] chan_a_in,
    input  wire logic [DW-1:0] chan_b_in,
    output logic      [DW-1:0] chan_a_out_bus,
    output logic               chan_a_oe_n,
    output logic               chan_a_valid,
    output logic               chan_a_mux_b,
    output logic      [DW-1:0] chan_b_out_bus,
    output logic               chan_b_oe_n,
    output logic               chan_b_valid,
    output logic      [10:0]   full_scale_mv,
    output logic               pwr_global_dn,
    output logic               pwr_stby_a,
    output logic               pwr_stby_b,
    output logic               low_power
);
    localparam int EW = DW + gop_pkg::FRAC + 1;

    function automatic logic [DW-1:0] sat(input logic signed [24:0] v);
        logic signed [24:0] hi;
        logic signed [24:0] lo;
        hi = 25'sd1 <<< (DW - 1);
        lo = -hi;
        if (v >= hi)
            sat = {1'b0, {(DW-1){1'b1}}};
        else if (v < lo)
            sat = {1'b1, {(DW-1){1'b0}}};
        else
            sat = v[DW-1:0];
    endfunction

    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [3:0] gain_q;
    logic       ofs_en_q;
    logic [3:0] tc_q;
    logic [3:0] pmode_q;
    logic [7:0] rdata_q;

    wire wr_gain  = reg_wr && (reg_addr == gop_pkg::ADR_GAIN);
    wire wr_ofs   = reg_wr && (reg_addr == gop_pkg::ADR_OFS);
    wire wr_pmode = reg_wr && (reg_addr == gop_pkg::ADR_PMODE);
    // out-of-range gain codes are dropped, the last legal one stays
    wire gain_ok  = reg_wdata[3:0] <= gop_pkg::GAIN_MAX;

    always_ff @(posedge clk) begin
        if (srst) begin
            gain_q   <= gop_pkg::GAIN_RST;
            ofs_en_q <= 1'b0;
            tc_q     <= gop_pkg::TC_RST;
            pmode_q  <= gop_pkg::PM_NORM;
        end else begin
            if (wr_gain && gain_ok)
                gain_q <= reg_wdata[3:0];
            if (wr_ofs) begin
                ofs_en_q <= reg_wdata[gop_pkg::OFS_EN_BIT];
                tc_q     <= reg_wdata[gop_pkg::OFS_TC_LSB +: 4];
            end
            if (wr_pmode)
                pmode_q <= reg_wdata[3:0];
        end
    end

    // ---------------------------------------------------------------
    // power mode decode
    // ---------------------------------------------------------------
    // a nonzero register code wins; otherwise the three pins decide
    wire [2:0] pins = {ctl_pin_one, ctl_pin_two, ctl_pin_three};
    wire       use_reg = pmode_q != gop_pkg::PM_NORM;
    wire [3:0] pin_code = (pins == 3'b100) ? gop_pkg::PM_GLB   :
                          (pins == 3'b101) ? gop_pkg::PM_STBYB :
                          (pins == 3'b110) ? gop_pkg::PM_STBYA :
                          (pins == 3'b111) ? gop_pkg::PM_MUX   :
                          gop_pkg::PM_NORM;
    wire [3:0] mode = use_reg ? pmode_q : pin_code;
    gop_pkg::gop_pwr_s pwr;
    assign pwr.pd_glb = mode == gop_pkg::PM_GLB;
    assign pwr.stby_b = mode == gop_pkg::PM_STBYB;
    assign pwr.stby_a = mode == gop_pkg::PM_STBYA;
    assign pwr.bdis_b = (mode == gop_pkg::PM_BDISB) ||
                        (mode == gop_pkg::PM_BDIS2);
    assign pwr.bdis_a = (mode == gop_pkg::PM_BDISA) ||
                        (mode == gop_pkg::PM_BDIS2);
    assign pwr.mux    = mode == gop_pkg::PM_MUX;

    // ---------------------------------------------------------------
    // slow clock detect
    // ---------------------------------------------------------------
    logic [7:0] gap_q;
    logic       lp_q;
    wire        gap_full = gap_q == 8'(gop_pkg::SLOW_CYC);

    always_ff @(posedge clk) begin
        if (srst) begin
            gap_q <= 8'h00;
            lp_q  <= 1'b0;
        end else begin
            gap_q <= samp_tick ? 8'h00 : (gap_full ? gap_q : gap_q + 8'h01);
            lp_q  <= !samp_tick && gap_full;
        end
    end

    // ---------------------------------------------------------------
    // per channel offset loop, gain and output
    // ---------------------------------------------------------------
    // reserved codes act as the slowest legal setting
    wire [3:0] tc_eff = (tc_q > gop_pkg::TC_MAX) ? gop_pkg::TC_MAX : tc_q;
    wire [5:0] shift  = 6'(gop_pkg::SH_BASE) + {2'b00, tc_eff};
    wire [11:0] gk    = gop_pkg::gain_k(gain_q);

    logic [DW-1:0] din [2];
    logic          off [2];
    logic          bdis[2];
    logic [DW-1:0] dg  [2];
    logic [7:0]    corr[2];
    logic          dv  [2];
    logic [10:0]   wk  [2];
    assign din[0]  = chan_a_in;
    assign din[1]  = chan_b_in;
    assign off[0]  = pwr.pd_glb || pwr.stby_a || lp_q;
    assign off[1]  = pwr.pd_glb || pwr.stby_b || lp_q;
    assign bdis[0] = pwr.bdis_a;
    assign bdis[1] = pwr.bdis_b || pwr.mux;

    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic signed [EW-1:0] est_q;
        logic [10:0]          wk_q;
        logic [DW-1:0]        dg_q;
        wire signed [EW-1:0] xs = EW'($signed(din[c])) <<< gop_pkg::FRAC;
        wire signed [EW-1:0] est_d = est_q + ((xs - est_q) >>> shift);
        wire signed [EW-1:0] e_int = est_q >>> gop_pkg::FRAC;
        wire signed [EW-1:0] lim = EW'(gop_pkg::OFS_LIM);
        // correction held to about 10 mV of codes, either sign
        wire signed [EW-1:0] cr = (e_int > lim) ? lim :
                                  (e_int < -lim) ? -lim : e_int;
        wire signed [12:0] xc = 13'($signed(din[c])) - 13'(cr);
        wire signed [24:0] pr = 25'(xc * $signed({1'b0, gk}));
        wire [10:0] ld = pwr.pd_glb ? 11'(gop_pkg::GLB_CYC) :
                         off[c]     ? 11'(gop_pkg::STBY_CYC) :
                         11'(gop_pkg::BUF_CYC);
        wire down = off[c] || bdis[c];

        always_ff @(posedge clk) begin
            if (srst) begin
                est_q <= '0;
                wk_q  <= 11'h000;
                dg_q  <= '0;
            end else begin
                if (ofs_en_q)
                    est_q <= est_d;
                // estimate simply holds while disabled
                if (down && ld > wk_q)
                    wk_q <= ld;
                else if (!down && wk_q != 11'h000)
                    wk_q <= wk_q - 11'h001;
                dg_q <= sat(pr >>> gop_pkg::GK_FRAC);
            end
        end
        assign dg[c]   = dg_q;
        assign corr[c] = 8'(cr);
        assign wk[c]   = wk_q;
        assign dv[c]   = !down && wk_q == 11'h000;
    end

    // ---------------------------------------------------------------
    // output pins
    // ---------------------------------------------------------------
    logic [DW-1:0] a_q;
    logic [DW-1:0] b_q;
    logic          a_oen_q;
    logic          b_oen_q;
    logic          sel_q;
    logic          glb_q;
    logic          sta_q;
    logic          stb_q;
    wire           a_sel_b = pwr.mux && sel_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            a_q     <= '0;
            b_q     <= '0;
            a_oen_q <= 1'b1;
            b_oen_q <= 1'b1;
            sel_q   <= 1'b0;
            glb_q   <= 1'b0;
            sta_q   <= 1'b0;
            stb_q   <= 1'b0;
        end else begin
            sel_q   <= pwr.mux ? !sel_q : 1'b0;
            a_q     <= a_sel_b ? dg[1] : dg[0];
            b_q     <= dg[1];
            a_oen_q <= pwr.pd_glb || lp_q || bdis[0];
            b_oen_q <= pwr.pd_glb || lp_q || bdis[1];
            glb_q   <= pwr.pd_glb;
            sta_q   <= pwr.stby_a;
            stb_q   <= pwr.stby_b;
        end
    end

    assign chan_a_out_bus = a_q;
    assign chan_b_out_bus = b_q;
    assign chan_a_oe_n    = a_oen_q;
    assign chan_b_oe_n    = b_oen_q;
    assign chan_a_mux_b   = !sel_q && pwr.mux;
    // in mux mode b's buffer is off on purpose; only its converter counts
    assign chan_a_valid   = dv[0] && (!pwr.mux || !off[1]);
    assign chan_b_valid   = dv[1] && !pwr.mux;
    assign full_scale_mv  = gop_pkg::fs_mv(gain_q);
    assign pwr_global_dn  = glb_q;
    assign pwr_stby_a     = sta_q;
    assign pwr_stby_b     = stb_q;
    assign low_power      = lp_q;

    // ---------------------------------------------------------------
    // register read port
    // ---------------------------------------------------------------
    wire [7:0] stat = {1'b0, lp_q, sel_q, pwr.mux, dv[1], dv[0],
                       stb_q || sta_q, glb_q};
    wire [7:0] rmux;
    assign rmux = (reg_addr == gop_pkg::ADR_GAIN)  ? {4'h0, gain_q} :
                  (reg_addr == gop_pkg::ADR_OFS)   ? {tc_q, 3'b000, ofs_en_q} :
                  (reg_addr == gop_pkg::ADR_PMODE) ? {4'h0, pmode_q} :
                  (reg_addr == gop_pkg::ADR_STAT)  ? stat :
                  (reg_addr == gop_pkg::ADR_CORRA) ? corr[0] :
                  (reg_addr == gop_pkg::ADR_CORRB) ? corr[1] : 8'h00;

    always_ff @(posedge clk) begin
        if (srst)
            rdata_q <= 8'h00;
        else
            rdata_q <= reg_rd ? rmux : 8'h00;
    end
    assign reg_rdata = rdata_q;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_glb_exit;
        pwr.pd_glb ##1 !pwr.pd_glb;
    endsequence
    sequence s_mux2;
        pwr.mux [*2];
    endsequence

    property p_gain_rst;
        $fell(srst) |-> gain_q == gop_pkg::GAIN_RST && !ofs_en_q;
    endproperty
    a_gain_rst: assert property (p_gain_rst)
        else $error("gain or offset enable not cleared by reset");
    property p_gain_max;
        wr_gain && !gain_ok |=> $stable(gain_q);
    endproperty
    a_gain_max: assert property (p_gain_max)
        else $error("illegal gain code accepted");
    property p_fs;
        gain_q > $past(gain_q) |-> full_scale_mv < $past(full_scale_mv);
    endproperty
    a_fs: assert property (p_fs)
        else $error("full scale did not shrink with gain");
    property p_frz;
        !ofs_en_q [*2] |-> $stable(g_ch[0].est_q) && $stable(g_ch[1].est_q);
    endproperty
    a_frz: assert property (p_frz)
        else $error("offset estimate moved while frozen");
    property p_lim;
        $signed(corr[0]) <= 8'sd10 && $signed(corr[0]) >= -8'sd10;
    endproperty
    a_lim: assert property (p_lim)
        else $error("offset correction beyond limit");
    property p_glb_wake;
        s_glb_exit |-> !chan_a_valid [*8] ##0 g_ch[0].wk_q > 11'd1900;
    endproperty
    a_glb_wake: assert property (p_glb_wake)
        else $error("global power down wake too short");
    property p_glb_hiz;
        pwr.pd_glb |=> chan_a_oe_n && chan_b_oe_n && pwr_global_dn;
    endproperty
    a_glb_hiz: assert property (p_glb_hiz)
        else $error("outputs driven in global power down");
    property p_mux;
        s_mux2 |=> sel_q != $past(sel_q) && chan_b_oe_n;
    endproperty
    a_mux: assert property (p_mux)
        else $error("mux mode did not alternate");
    property p_bdis;
        mode == gop_pkg::PM_BDISB |=> chan_b_oe_n && !pwr_stby_b;
    endproperty
    a_bdis: assert property (p_bdis)
        else $error("channel b buffer not disabled");
    property p_buf_wake;
        $fell(pwr.bdis_b) && !off[1] && wk[1] <= 11'd10
            |-> ##[9:11] dv[1];
    endproperty
    a_buf_wake: assert property (p_buf_wake)
        else $error("buffer wake not about 100 ns");
    property p_lp;
        !samp_tick [*8] ##0 gap_q == 8'd100 ##1 !samp_tick |-> low_power;
    endproperty
    a_lp: assert property (p_lp)
        else $error("slow clock not detected");
    property p_tc;
        shift <= 6'd29;
    endproperty
    a_tc: assert property (p_tc)
        else $error("time constant beyond longest code");
endmodule

// ### tb/gop_host.sv
// host model: register bus master, power pins and sample tick source
`timescale 1ns/1ps
module gop_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic            ctl_pin_one,
    output logic            ctl_pin_two,
    output logic            ctl_pin_three,
    output logic            samp_tick
);
    logic       tick_run = 1'b1;
    logic [1:0] tick_cnt = 2'h0;

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        {ctl_pin_one, ctl_pin_two, ctl_pin_three} = 3'h0;
        samp_tick = 1'b0;
    end

    // one sample every four clocks, far above the slow-clock limit
    always @(posedge clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        samp_tick <= tick_run && (tick_cnt == 2'h0);
    end

    // -------------------------------------------------------------------
    // bus cycles: address beside data, one strobe cycle
    // -------------------------------------------------------------------
    // released lines show the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask

    // pins are only used while the mode field stays zero
    task automatic pins(input logic [2:0] p);
        @(posedge clk);
        {ctl_pin_one, ctl_pin_two, ctl_pin_three} <= p;
    endtask
endmodule

// ### tb/gop_ctrl_tb.sv
// self-checking bench for the gain, offset and power-down control
`timescale 1ns/1ps
module gop_ctrl_tb;
    logic                   clk, srst, reg_wr, reg_rd, samp_tick;
    logic [7:0]             reg_addr, reg_wdata, reg_rdata;
    logic                   ctl_pin_one, ctl_pin_two, ctl_pin_three;
    logic [gop_pkg::DW-1:0] chan_a_in, chan_b_in, a_prev, a_dly, v;
    logic [gop_pkg::DW-1:0] chan_a_out_bus, chan_b_out_bus;
    logic                   chan_a_oe_n, chan_a_valid, chan_a_mux_b;
    logic                   chan_b_oe_n, chan_b_valid, low_power;
    logic                   pwr_global_dn, pwr_stby_a, pwr_stby_b;
    logic [10:0]            full_scale_mv, fs_prev;
    logic [7:0]             exp_q[$];
    logic                   rd_seen = 1'b0;
    logic                   chk_data = 1'b0;
    logic                   rnd_on = 1'b0;
    logic                   mx;
    logic [31:0]            r;
    logic [3:0]             modes[7] = '{4'h9, 4'ha, 4'hb, 4'hc, 4'hd,
                                         4'he, 4'hf};
    logic [4:0]             exp_pw[7] = '{5'h01, 5'h02, 5'h03, 5'h13,
                                          5'h04, 5'h08, 5'h01};
    logic [4:0]             msk_pw[7] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f,
                                          5'h1c, 5'h1c, 5'h1f};
    logic [2:0]             exp_pin[4] = '{3'h4, 3'h1, 3'h2, 3'h0};
    int                     num_errors = 0;
    int                     total_checks = 0;
    int                     n;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    gop_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .ctl_pin_one(ctl_pin_one),
        .ctl_pin_two(ctl_pin_two), .ctl_pin_three(ctl_pin_three),
        .samp_tick(samp_tick));

    gop_ctrl dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ctl_pin_one(ctl_pin_one),
        .ctl_pin_two(ctl_pin_two), .ctl_pin_three(ctl_pin_three),
        .samp_tick(samp_tick), .chan_a_in(chan_a_in),
        .chan_b_in(chan_b_in), .chan_a_out_bus(chan_a_out_bus),
        .chan_a_oe_n(chan_a_oe_n), .chan_a_valid(chan_a_valid),
        .chan_a_mux_b(chan_a_mux_b), .chan_b_out_bus(chan_b_out_bus),
        .chan_b_oe_n(chan_b_oe_n), .chan_b_valid(chan_b_valid),
        .full_scale_mv(full_scale_mv), .pwr_global_dn(pwr_global_dn),
        .pwr_stby_a(pwr_stby_a), .pwr_stby_b(pwr_stby_b),
        .low_power(low_power));

    // -------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) check(1'b0, "read data not expected");
            else check(reg_rdata === exp_q.pop_front(), "read data");
        end
        // gain stage and output pins are two register stages deep
        if (chk_data) check(chan_a_out_bus === a_dly, "channel A data");
        rd_seen = reg_rd;
        a_dly = a_prev;
        a_prev = chan_a_in;
    end

    always @(posedge clk) begin
        r = $urandom;
        if (rnd_on) begin
            chan_a_in <= r[gop_pkg::DW-1:0];
            chan_b_in <= r[gop_pkg::DW+15:16];
        end
    end

    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        srst = 1'b1;
        chan_a_in = '0;
        chan_b_in = '0;
        void'($urandom(32'hbf46_b649));
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        rd_exp(gop_pkg::ADR_GAIN, 8'h00);
        rd_exp(gop_pkg::ADR_OFS, 8'h00);
        rd_exp(8'h40, 8'h00);
        host.wr(8'h40, 8'h5a);
        check(full_scale_mv === 11'h7d0, "span at 0 dB");
        // unity gain, no correction: output is the input two cycles on
        rnd_on = 1'b1;
        repeat (4) @(posedge clk);
        chk_data = 1'b1;
        repeat (200) @(posedge clk);
        chk_data = 1'b0;
        rnd_on = 1'b0;
        fs_prev = full_scale_mv;
        for (int g = 1; g <= 12; g++) begin
            host.wr(gop_pkg::ADR_GAIN, 8'(g));
            rd_exp(gop_pkg::ADR_GAIN, 8'(g));
            check(full_scale_mv < fs_prev, "span shrinks");
            fs_prev = full_scale_mv;
        end
        check(full_scale_mv === 11'h3e8, "span at 6 dB");
        host.wr(gop_pkg::ADR_GAIN, 8'h0d);
        rd_exp(gop_pkg::ADR_GAIN, 8'h0c);
        chan_a_in <= 11'h064;
        repeat (4) @(posedge clk);
        check(chan_a_out_bus >= 11'h0c4 && chan_a_out_bus <= 11'h0c8,
              "output doubled at 6 dB");
        host.wr(gop_pkg::ADR_GAIN, 8'h00);
        for (int i = 0; i < 7; i++) begin
            host.wr(gop_pkg::ADR_PMODE, {4'h0, modes[i]});
            // long enough for a re-enabled buffer to finish its wake
            repeat (12) @(posedge clk);
            check((({pwr_global_dn, pwr_stby_a, pwr_stby_b, chan_a_oe_n,
                    chan_b_oe_n} ^ exp_pw[i]) & msk_pw[i]) === 5'h00,
                  "mode outputs");
        end
        mx = chan_a_mux_b;
        @(posedge clk);
        check(chan_a_mux_b === ~mx, "mux slot alternates");
        host.wr(gop_pkg::ADR_PMODE, 8'h0c);
        repeat (5) @(posedge clk);
        host.wr(gop_pkg::ADR_PMODE, 8'h00);
        repeat (1000) @(posedge clk);
        check(chan_a_valid === 1'b0, "global wake too early");
        for (n = 0; n < 1100 && chan_a_valid !== 1'b1; n++) @(posedge clk);
        check(n < 1100, "global wake too late");
        host.wr(gop_pkg::ADR_PMODE, 8'h0d);
        repeat (5) @(posedge clk);
        host.wr(gop_pkg::ADR_PMODE, 8'h00);
        @(posedge clk);
        check(chan_b_valid === 1'b0, "standby wake too early");
        for (n = 0; n < 150 && chan_b_valid !== 1'b1; n++) @(posedge clk);
        check(n < 150, "standby wake too late");
        host.wr(gop_pkg::ADR_PMODE, 8'h0b);
        repeat (5) @(posedge clk);
        host.wr(gop_pkg::ADR_PMODE, 8'h00);
        for (n = 0; n < 20 && (chan_a_valid !== 1'b1 ||
             chan_a_oe_n !== 1'b0); n++) @(posedge clk);
        check(n < 20, "buffer wake too late");
        for (int p = 4; p < 8; p++) begin
            host.pins(3'(p));
            repeat (3) @(posedge clk);
            check({pwr_global_dn, pwr_stby_a, pwr_stby_b} === exp_pin[p-4],
                  "pin mode");
        end
        check(chan_b_oe_n === 1'b1, "mux by pins");
        host.pins(3'h0);
        // constant dc on A, silence on B
        chan_a_in <= 11'h01e;
        chan_b_in <= 11'h000;
        repeat (4) @(posedge clk);
        check(chan_a_out_bus === 11'h01e, "no correction yet");
        host.wr(gop_pkg::ADR_OFS, 8'h01);
        rd_exp(gop_pkg::ADR_OFS, 8'h01);
        repeat (30000) @(posedge clk);
        check(chan_a_out_bus < 11'h01e && chan_a_out_bus > 11'h014,
              "offset removed");
        check(chan_b_out_bus === 11'h000, "channel B untouched");
        rd_exp(gop_pkg::ADR_CORRB, 8'h00);
        host.wr(gop_pkg::ADR_OFS, 8'hb0);
        rd_exp(gop_pkg::ADR_OFS, 8'hb0);
        @(posedge clk);
        v = chan_a_out_bus;
        repeat (2000) @(posedge clk);
        check(chan_a_out_bus === v, "estimate frozen");
        chan_a_in <= 11'h014;
        repeat (3) @(posedge clk);
        check(chan_a_out_bus === v - 11'h00a, "frozen value applied");
        host.tick_run <= 1'b0;
        repeat (150) @(posedge clk);
        check(low_power === 1'b1, "slow clock low power");
        host.tick_run <= 1'b1;
        for (n = 0; n < 20 && low_power !== 1'b0; n++) @(posedge clk);
        check(n < 20, "low power exit");
        repeat (2) @(posedge clk);
        check(exp_q.size() == 0, "reads left unanswered");
        tally_and_finish();
    end
endmodule
